// [shared/csc_pkg.sv]
// constants and types for the clock and standby control block
// What this block does
// - the pll multiplier code maps 00111,01001,01011,01111,10011,10111,11000 to x8,x10,x12,x16,x20,x24,x25.
// - the main oscillator wait code 00000..01111 selects 2,4,8,16,32,256,512,1024,2048,4096,16384..524288 cycles.
// - a wait request enters sleep or all-module stop when standby_select is 0 and software standby when it is 1.
// - the power mode code maps 000,010,011,100,101,110,111 to high, mid 1A, 1B, 2A, 2B, low 1, low 2.
// - sleep return clock code 001 picks the fast on-chip oscillator and 010 the main oscillator.
// - the drive code 01, 10, 11 selects 1-8 MHz, 8.1-15.9 MHz and 16-20 MHz drive.
// - system, peripheral, converter, bus and flash clocks each have their own divider.
// - the bus clock pin gives the bus clock or high under bus_clk_pin_stop, and the bus clock or its half.
// - the fast on-chip oscillator runs at 32, 36.864, 40 or 50 MHz and has power control.
// - the fast oscillator wait time comes from its own wait control setting.
// - one module stop bit gates both the dma and data transfer controller clocks.
// - an enable bit allows all-module clock stop mode as a low-power state.
package csc_pkg;
    localparam logic [4:0] CSC_PLL_X8 = 5'h07;
    localparam logic [4:0] CSC_PLL_X10 = 5'h09;
    localparam logic [4:0] CSC_PLL_X12 = 5'h0B;
    localparam logic [4:0] CSC_PLL_X16 = 5'h0F;
    localparam logic [4:0] CSC_PLL_X20 = 5'h13;
    localparam logic [4:0] CSC_PLL_X24 = 5'h17;
    localparam logic [4:0] CSC_PLL_X25 = 5'h18;
    localparam logic [4:0] CSC_WAIT_MAX_CODE = 5'h0F;
    localparam logic [2:0] CSC_PM_HIGH = 3'h0;
    localparam logic [2:0] CSC_PM_MID1A = 3'h2;
    localparam logic [2:0] CSC_PM_MID1B = 3'h3;
    localparam logic [2:0] CSC_PM_MID2A = 3'h4;
    localparam logic [2:0] CSC_PM_MID2B = 3'h5;
    localparam logic [2:0] CSC_PM_LOW1 = 3'h6;
    localparam logic [2:0] CSC_PM_LOW2 = 3'h7;
    localparam logic [2:0] CSC_RET_FAST = 3'h1;
    localparam logic [2:0] CSC_RET_MAIN = 3'h2;
    localparam logic [1:0] CSC_DRV_LOW = 2'h1;
    localparam logic [1:0] CSC_DRV_MID = 2'h2;
    localparam logic [1:0] CSC_DRV_HIGH = 2'h3;
    localparam logic [1:0] CSC_FOSC_32 = 2'h0;
    localparam logic [1:0] CSC_FOSC_36864 = 2'h1;
    localparam logic [1:0] CSC_FOSC_40 = 2'h2;
    localparam logic [1:0] CSC_FOSC_50 = 2'h3;
    localparam int CSC_NDIV = 5;
    localparam int CSC_DIV_SYS = 0;
    localparam int CSC_DIV_PER = 1;
    localparam int CSC_DIV_CNV = 2;
    localparam int CSC_DIV_BUS = 3;
    localparam int CSC_DIV_FLS = 4;
    localparam logic [3:0] CSC_DIV_RST = 4'h0;
    localparam logic [19:0] CSC_CNT_ONE = 20'h0_0001;
    localparam logic [19:0] CSC_CNT_ZERO = 20'h0_0000;

    // one-hot standby states
    typedef enum logic [3:0] {
        CSC_RUN = 4'b0001,
        CSC_SLEEP = 4'b0010,
        CSC_ALLSTOP = 4'b0100,
        CSC_SWSTBY = 4'b1000
    } csc_state_t;

    typedef struct packed {
        logic [4:0] pll_mult_sel;
        logic [4:0] main_osc_wait_sel;
        logic standby_select;
        logic [2:0] power_mode_sel;
        logic [2:0] sleep_return_clk_sel;
        logic [1:0] main_osc_drive_sel;
        logic [1:0] fast_osc_freq_sel;
        logic fast_osc_power_on;
        logic [4:0] fast_osc_wait_ctrl;
        logic bus_clk_pin_stop;
        logic bus_clk_pin_half;
        logic dma_xfer_module_stop;
        logic all_clock_stop_enable;
        logic [CSC_NDIV*4-1:0] div_sel;
    } csc_cfg_t;

    typedef struct packed {
        logic [4:0] pll_factor;
        logic [19:0] main_wait_cycles;
        logic [19:0] fast_wait_cycles;
        logic [6:0] power_mode_onehot;
        logic ret_fast;
        logic ret_main;
        logic [2:0] drive_onehot;
        logic [1:0] fast_osc_freq;
        logic fast_osc_power_on;
    } csc_stat_t;
endpackage : csc_pkg

// [src/csc_top.sv]
// clock dividers, bus clock pin and standby control
`timescale 1ns/1ps
module csc_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire csc_pkg::csc_cfg_t cfg,
    input wire logic src_tick,
    input wire logic wait_req,
    input wire logic wake_req,
    output csc_pkg::csc_stat_t stat,
    output logic [csc_pkg::CSC_NDIV-1:0] clk_en,
    output logic dma_xfer_clk_en,
    output logic bus_clk_pin,
    output csc_pkg::csc_state_t standby_state
);
    typedef struct packed {
        csc_pkg::csc_stat_t stat;
        logic [csc_pkg::CSC_NDIV*4-1:0] cnt;
        logic [csc_pkg::CSC_NDIV-1:0] clk_en;
        logic dma_en;
        logic bus_half;
        logic pin;
        csc_pkg::csc_state_t st;
    } csc_st_t;

    csc_st_t s;
    csc_st_t next_s;

    // wait code to cycle count; codes above the top give the longest
    function automatic logic [19:0] csc_wait(input logic [4:0] c);
        logic [19:0] r;
        r = csc_pkg::CSC_CNT_ONE;
        unique case (c)
            5'h00: r = csc_pkg::CSC_CNT_ONE << 1;
            5'h01: r = csc_pkg::CSC_CNT_ONE << 2;
            5'h02: r = csc_pkg::CSC_CNT_ONE << 3;
            5'h03: r = csc_pkg::CSC_CNT_ONE << 4;
            5'h04: r = csc_pkg::CSC_CNT_ONE << 5;
            5'h05: r = csc_pkg::CSC_CNT_ONE << 8;
            5'h06: r = csc_pkg::CSC_CNT_ONE << 9;
            5'h07: r = csc_pkg::CSC_CNT_ONE << 10;
            5'h08: r = csc_pkg::CSC_CNT_ONE << 11;
            5'h09: r = csc_pkg::CSC_CNT_ONE << 12;
            5'h0A: r = csc_pkg::CSC_CNT_ONE << 14;
            5'h0B: r = csc_pkg::CSC_CNT_ONE << 15;
            5'h0C: r = csc_pkg::CSC_CNT_ONE << 16;
            5'h0D: r = csc_pkg::CSC_CNT_ONE << 17;
            5'h0E: r = csc_pkg::CSC_CNT_ONE << 18;
            default: r = csc_pkg::CSC_CNT_ONE << 19;
        endcase
        return r;
    endfunction : csc_wait

    // multiplier decode; an undefined code yields factor zero
    function automatic logic [4:0] csc_pll(input logic [4:0] c);
        logic [4:0] r;
        r = 5'h00;
        unique case (c)
            csc_pkg::CSC_PLL_X8: r = 5'h08;
            csc_pkg::CSC_PLL_X10: r = 5'h0A;
            csc_pkg::CSC_PLL_X12: r = 5'h0C;
            csc_pkg::CSC_PLL_X16: r = 5'h10;
            csc_pkg::CSC_PLL_X20: r = 5'h14;
            csc_pkg::CSC_PLL_X24: r = 5'h18;
            csc_pkg::CSC_PLL_X25: r = 5'h19;
            default: r = 5'h00;
        endcase
        return r;
    endfunction : csc_pll

    always_comb begin
        logic [3:0] c;
        logic [3:0] d;
        logic idle;
        c = 4'h0;
        d = 4'h0;
        next_s = s;
        idle = (s.st != csc_pkg::CSC_RUN);
        // status decodes
        next_s.stat.pll_factor = csc_pll(cfg.pll_mult_sel);
        next_s.stat.main_wait_cycles = csc_wait(cfg.main_osc_wait_sel);
        next_s.stat.fast_wait_cycles = csc_wait(cfg.fast_osc_wait_ctrl);
        next_s.stat.power_mode_onehot = '0;
        unique case (cfg.power_mode_sel)
            csc_pkg::CSC_PM_HIGH: next_s.stat.power_mode_onehot = 7'h01;
            csc_pkg::CSC_PM_MID1A: next_s.stat.power_mode_onehot = 7'h02;
            csc_pkg::CSC_PM_MID1B: next_s.stat.power_mode_onehot = 7'h04;
            csc_pkg::CSC_PM_MID2A: next_s.stat.power_mode_onehot = 7'h08;
            csc_pkg::CSC_PM_MID2B: next_s.stat.power_mode_onehot = 7'h10;
            csc_pkg::CSC_PM_LOW1: next_s.stat.power_mode_onehot = 7'h20;
            csc_pkg::CSC_PM_LOW2: next_s.stat.power_mode_onehot = 7'h40;
            default: next_s.stat.power_mode_onehot = 7'h00;
        endcase
        next_s.stat.ret_fast = (cfg.sleep_return_clk_sel == csc_pkg::CSC_RET_FAST);
        next_s.stat.ret_main = (cfg.sleep_return_clk_sel == csc_pkg::CSC_RET_MAIN);
        next_s.stat.drive_onehot = {cfg.main_osc_drive_sel == csc_pkg::CSC_DRV_HIGH,
                                    cfg.main_osc_drive_sel == csc_pkg::CSC_DRV_MID,
                                    cfg.main_osc_drive_sel == csc_pkg::CSC_DRV_LOW};
        next_s.stat.fast_osc_freq = cfg.fast_osc_freq_sel;
        next_s.stat.fast_osc_power_on = cfg.fast_osc_power_on;
        // dividers: enable pulse every (code+1) source ticks; frozen outside run
        for (int i = 0; i < csc_pkg::CSC_NDIV; i++) begin
            c = s.cnt[i*4 +: 4];
            d = cfg.div_sel[i*4 +: 4];
            next_s.clk_en[i] = 1'b0;
            if (src_tick && !idle) begin
                if (c >= d) begin
                    next_s.cnt[i*4 +: 4] = csc_pkg::CSC_DIV_RST;
                    next_s.clk_en[i] = 1'b1;
                end else begin
                    next_s.cnt[i*4 +: 4] = c + 4'h1;
                end
            end
        end
        next_s.dma_en = next_s.clk_en[csc_pkg::CSC_DIV_SYS] && !cfg.dma_xfer_module_stop;
        // bus clock pin: toggles per bus tick, or per second tick when halved
        if (next_s.clk_en[csc_pkg::CSC_DIV_BUS]) begin
            next_s.bus_half = !s.bus_half;
        end
        if (cfg.bus_clk_pin_stop) begin
            next_s.pin = 1'b1;
        end else if (next_s.clk_en[csc_pkg::CSC_DIV_BUS] && (!cfg.bus_clk_pin_half || !s.bus_half)) begin
            next_s.pin = !s.pin;
        end
        // standby sequencing
        unique case (s.st)
            csc_pkg::CSC_RUN: begin
                if (wait_req) begin
                    if (cfg.standby_select) begin
                        next_s.st = csc_pkg::CSC_SWSTBY;
                    end else if (cfg.all_clock_stop_enable) begin
                        next_s.st = csc_pkg::CSC_ALLSTOP;
                    end else begin
                        next_s.st = csc_pkg::CSC_SLEEP;
                    end
                end
            end
            csc_pkg::CSC_SLEEP, csc_pkg::CSC_ALLSTOP, csc_pkg::CSC_SWSTBY: begin
                if (wake_req) begin
                    next_s.st = csc_pkg::CSC_RUN;
                end
            end
            default: next_s.st = csc_pkg::CSC_RUN;
        endcase
    end

    // reset leaves the pin high and the block running
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.pin <= 1'b1;
            s.st <= csc_pkg::CSC_RUN;
        end else begin
            s <= next_s;
        end
    end

    assign stat = s.stat;
    assign clk_en = s.clk_en;
    assign dma_xfer_clk_en = s.dma_en;
    assign bus_clk_pin = s.pin;
    assign standby_state = s.st;

    property p_standby_select_one;
        @(posedge clock) disable iff (!rst_n)
        (s.st == csc_pkg::CSC_RUN && wait_req && cfg.standby_select) |=> (s.st == csc_pkg::CSC_SWSTBY);
    endproperty
    a_standby_select_one: assert property (p_standby_select_one) else $error("standby select 1 did not enter software standby");
    property p_standby_select_zero;
        @(posedge clock) disable iff (!rst_n)
        (s.st == csc_pkg::CSC_RUN && wait_req && !cfg.standby_select) |=>
            (s.st == csc_pkg::CSC_SLEEP || s.st == csc_pkg::CSC_ALLSTOP);
    endproperty
    a_standby_select_zero: assert property (p_standby_select_zero) else $error("standby select 0 did not enter sleep");
    property p_all_clock_stop_enable;
        @(posedge clock) disable iff (!rst_n)
        (s.st == csc_pkg::CSC_RUN && wait_req && !cfg.standby_select && !cfg.all_clock_stop_enable) |=>
            (s.st == csc_pkg::CSC_SLEEP);
    endproperty
    a_all_clock_stop_enable: assert property (p_all_clock_stop_enable) else $error("all stop entered while disabled");
    property p_pll;
        @(posedge clock) disable iff (!rst_n)
        (cfg.pll_mult_sel == csc_pkg::CSC_PLL_X25) |=> (stat.pll_factor == 5'h19);
    endproperty
    a_pll: assert property (p_pll) else $error("pll x25 decode wrong");
    property p_wait;
        @(posedge clock) disable iff (!rst_n)
        (cfg.main_osc_wait_sel == csc_pkg::CSC_WAIT_MAX_CODE) |=> (stat.main_wait_cycles == 20'h8_0000);
    endproperty
    a_wait: assert property (p_wait) else $error("longest main wait wrong");
    property p_pm;
        @(posedge clock) disable iff (!rst_n)
        (cfg.power_mode_sel == csc_pkg::CSC_PM_LOW2) |=> (stat.power_mode_onehot == 7'h40);
    endproperty
    a_pm: assert property (p_pm) else $error("low speed 2 decode wrong");
    property p_ret;
        @(posedge clock) disable iff (!rst_n)
        (cfg.sleep_return_clk_sel == csc_pkg::CSC_RET_MAIN) |=> (stat.ret_main && !stat.ret_fast);
    endproperty
    a_ret: assert property (p_ret) else $error("return source decode wrong");
    property p_drv;
        @(posedge clock) disable iff (!rst_n)
        (cfg.main_osc_drive_sel == csc_pkg::CSC_DRV_MID) |=> (stat.drive_onehot == 3'h2);
    endproperty
    a_drv: assert property (p_drv) else $error("drive decode wrong");
    property p_div;
        @(posedge clock) disable iff (!rst_n)
        (cfg.div_sel[3:0] == 4'h0 && src_tick && s.st == csc_pkg::CSC_RUN) |=> clk_en[csc_pkg::CSC_DIV_SYS];
    endproperty
    a_div: assert property (p_div) else $error("undivided system clock missed");
    property p_pin;
        @(posedge clock) disable iff (!rst_n)
        cfg.bus_clk_pin_stop |=> bus_clk_pin;
    endproperty
    a_pin: assert property (p_pin) else $error("stopped bus pin not high");
    property p_dma;
        @(posedge clock) disable iff (!rst_n)
        cfg.dma_xfer_module_stop |=> !dma_xfer_clk_en;
    endproperty
    a_dma: assert property (p_dma) else $error("dma clock ran while stopped");
    c_sw: cover property (@(posedge clock) disable iff (!rst_n) s.st == csc_pkg::CSC_SWSTBY);
    c_all: cover property (@(posedge clock) disable iff (!rst_n) s.st == csc_pkg::CSC_ALLSTOP);
    c_pin: cover property (@(posedge clock) disable iff (!rst_n) $rose(bus_clk_pin) && cfg.bus_clk_pin_half);
endmodule : csc_top

// [tb/csc_tb_top.sv]
// self-checking bench for the clock and standby control block
`timescale 1ns/1ps
module csc_tb_top;
    logic clock;
    logic rst_n;
    csc_pkg::csc_cfg_t cfg;
    csc_pkg::csc_cfg_t c;
    logic src_tick;
    logic wait_req;
    logic wake_req;
    csc_pkg::csc_stat_t stat;
    logic [csc_pkg::CSC_NDIV-1:0] clk_en;
    logic dma_xfer_clk_en;
    logic bus_clk_pin;
    csc_pkg::csc_state_t standby_state;
    int miscompares;
    int tests_run;
    int pulses [csc_pkg::CSC_NDIV];
    int toggles;
    int pin_low;
    logic last_pin;
    localparam int CFG_W = $bits(csc_pkg::csc_cfg_t);

    csc_top i_csc_top (.clock(clock), .rst_n(rst_n), .cfg(cfg), .src_tick(src_tick), .wait_req(wait_req),
        .wake_req(wake_req), .stat(stat), .clk_en(clk_en), .dma_xfer_clk_en(dma_xfer_clk_en),
        .bus_clk_pin(bus_clk_pin), .standby_state(standby_state));

    // 100 ns clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic close_out();
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk_val

    // divider phase is the design's choice, so counts may differ by one
    task automatic chk_cnt(input string what, input int exp, input int got);
        tests_run++;
        if (got > exp + 1 || got < exp - 1) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt

    task automatic chk_state(input csc_pkg::csc_state_t exp);
        tests_run++;
        if (standby_state !== exp) begin
            miscompares++;
            $display("CHECK FAILED standby_state expected %b seen %b", exp, standby_state);
        end
    endtask : chk_state

    function automatic logic [31:0] exp_pll(input logic [4:0] code);
        case (code)
            csc_pkg::CSC_PLL_X8: return 32'd8;
            csc_pkg::CSC_PLL_X10: return 32'd10;
            csc_pkg::CSC_PLL_X12: return 32'd12;
            csc_pkg::CSC_PLL_X16: return 32'd16;
            csc_pkg::CSC_PLL_X20: return 32'd20;
            csc_pkg::CSC_PLL_X24: return 32'd24;
            csc_pkg::CSC_PLL_X25: return 32'd25;
            default: return 32'd0;
        endcase
    endfunction : exp_pll

    function automatic logic [31:0] exp_wait(input logic [4:0] code);
        if (code < 5) return 32'd2 << code;
        if (code < 10) return 32'd256 << (code - 5);
        if (code < 16) return 32'd16384 << (code - 10);
        return 32'd524288;
    endfunction : exp_wait

    // one-hot position follows the order of the decoded codes; the skipped code gives zero
    function automatic logic [31:0] exp_hot(input int code, input int gap);
        if (code == gap) return 32'h0;
        return 32'h1 << (code > gap ? code - 1 : code);
    endfunction : exp_hot

    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic count(input int n);
        pulses = '{default: 0};
        toggles = 0;
        pin_low = 0;
        last_pin = bus_clk_pin;
        repeat (n) begin
            tick(1);
            for (int ch = 0; ch < csc_pkg::CSC_NDIV; ch++) pulses[ch] += int'(clk_en[ch]);
            toggles += int'(bus_clk_pin !== last_pin);
            pin_low += int'(bus_clk_pin !== 1'b1);
            last_pin = bus_clk_pin;
            chk_val("dma_xfer_clk_en", 32'(clk_en[0] & ~cfg.dma_xfer_module_stop), 32'(dma_xfer_clk_en));
        end
    endtask : count

    task automatic reset_check();
        chk_state(csc_pkg::CSC_RUN);
        chk_val("stat", 32'(stat == '0), 32'h1);
        chk_val("clk_en", 32'h0, 32'(clk_en));
        chk_val("bus_clk_pin", 32'h1, 32'(bus_clk_pin));
    endtask : reset_check

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        close_out();
    end

    initial begin
        int divs [5];
        int d;
        divs = '{0, 1, 2, 7, 15};
        rst_n = 1'b0;
        cfg = '0;
        src_tick = 1'b0;
        wait_req = 1'b0;
        wake_req = 1'b0;
        void'($urandom(32'h9310_9bd3));
        tick(8);
        reset_check();
        rst_n = 1'b1;
        // every code of each decoded field, other fields random
        for (int i = 0; i < 32; i++) begin
            c = csc_pkg::csc_cfg_t'(CFG_W'({$urandom, $urandom}));
            c.pll_mult_sel = 5'(i);
            c.main_osc_wait_sel = 5'(i);
            c.fast_osc_wait_ctrl = 5'(31 - i);
            c.power_mode_sel = 3'(i);
            c.sleep_return_clk_sel = 3'(i);
            c.main_osc_drive_sel = 2'(i);
            cfg = c;
            src_tick = 1'($urandom);
            tick(2);
            chk_val("pll_factor", exp_pll(5'(i)), 32'(stat.pll_factor));
            chk_val("main_wait_cycles", exp_wait(5'(i)), 32'(stat.main_wait_cycles));
            chk_val("fast_wait_cycles", exp_wait(5'(31 - i)), 32'(stat.fast_wait_cycles));
            chk_val("power_mode_onehot", exp_hot(i % 8, 1), 32'(stat.power_mode_onehot));
            chk_val("ret_fast", 32'(i % 8 == 1), 32'(stat.ret_fast));
            chk_val("ret_main", 32'(i % 8 == 2), 32'(stat.ret_main));
            chk_val("drive_onehot", exp_hot(i % 4, 0), 32'(stat.drive_onehot));
            chk_val("fast_osc_freq", 32'(c.fast_osc_freq_sel), 32'(stat.fast_osc_freq));
            chk_val("fast_osc_power_on", 32'(c.fast_osc_power_on), 32'(stat.fast_osc_power_on));
        end
        // each channel gets its own ratio so a shared divider shows up
        for (int k = 0; k < 5; k++) begin
            c = cfg;
            for (int ch = 0; ch < 5; ch++) c.div_sel[ch*4 +: 4] = 4'((divs[k] + ch) % 16);
            c.bus_clk_pin_half = k[0];
            c.dma_xfer_module_stop = k[1];
            c.bus_clk_pin_stop = 1'b0;
            cfg = c;
            // one source tick per bench cycle runs every divided clock at its ceiling of one pulse per code+1 cycles
            src_tick = 1'b1;
            tick(3);
            count(96);
            for (int ch = 0; ch < 5; ch++) begin
                d = (divs[k] + ch) % 16 + 1;
                chk_cnt("divider pulses", 96 / d, pulses[ch]);
            end
            chk_cnt("bus pin toggles", k[0] ? pulses[3] / 2 : pulses[3], toggles);
        end
        c = cfg;
        c.bus_clk_pin_stop = 1'b1;
        cfg = c;
        tick(2);
        count(40);
        chk_val("bus pin held high", 32'h0, 32'(pin_low));
        src_tick = 1'b0;
        tick(2);
        count(20);
        chk_val("pulses without ticks", 32'h0, 32'(pulses[0] + pulses[3]));
        // wait entry under each standby_select and stop-enable setting
        for (int k = 0; k < 4; k++) begin
            c = cfg;
            c.standby_select = k[0];
            c.all_clock_stop_enable = k[1];
            c.bus_clk_pin_stop = 1'b0;
            cfg = c;
            src_tick = 1'b1;
            tick(1);
            wait_req = 1'b1;
            tick(1);
            wait_req = 1'b0;
            chk_state(k[0] ? csc_pkg::CSC_SWSTBY : (k[1] ? csc_pkg::CSC_ALLSTOP : csc_pkg::CSC_SLEEP));
            count(6);
            chk_val("enables in standby", 32'h0, 32'(pulses[0] + pulses[3] + toggles));
            wait_req = 1'b1;
            tick(1);
            wait_req = 1'b0;
            chk_state(k[0] ? csc_pkg::CSC_SWSTBY : (k[1] ? csc_pkg::CSC_ALLSTOP : csc_pkg::CSC_SLEEP));
            if (k == 3) begin
                rst_n = 1'b0;
                tick(1);
                reset_check();
                rst_n = 1'b1;
            end
            wake_req = 1'b1;
            tick(1);
            wake_req = 1'b0;
            chk_state(csc_pkg::CSC_RUN);
        end
        close_out();
    end
endmodule : csc_tb_top
